// >>> src/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned CNT_W   = 4;
  localparam int unsigned SYNC_STAGES = 3;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_TXD  = 8'h08;
  localparam logic [7:0] OFF_RXD  = 8'h0C;
  localparam logic [7:0] OFF_INTF = 8'h10;
  localparam logic [7:0] OFF_INTE = 8'h14;

  // serial_mode_config fields
  localparam int unsigned MODE_LEN_LSB  = 8;
  localparam int unsigned MODE_LEN_MSB  = 11;
  localparam int unsigned MODE_PULL     = 5;
  localparam int unsigned MODE_UNDIV    = 4;
  localparam int unsigned MODE_LSBFIRST = 3;
  localparam int unsigned MODE_CLOCK_PHASE_SELECT     = 2;
  localparam int unsigned MODE_CLOCK_POLARITY_SELECT     = 1;
  localparam int unsigned MODE_MASTER   = 0;

  // channel_control fields
  localparam int unsigned CTRL_SOFTRST = 1;
  localparam int unsigned CTRL_ENABLE  = 0;

  // interrupt_flag_register / interrupt_enable_register fields
  localparam int unsigned INTF_BUSY = 7;
  localparam int unsigned INTF_OVR  = 3;
  localparam int unsigned INTF_TEND = 2;
  localparam int unsigned INTF_RBF  = 1;
  localparam int unsigned INTF_TBE  = 0;

  // Reset values and prohibited length
  localparam logic [3:0]  LEN_RESET      = 4'h7;
  localparam logic [3:0]  LEN_PROHIBITED = 4'h0;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam logic [3:0]  IE_RESET       = 4'h0;
  localparam logic        TBE_RESET      = 1'b1;

  // Master clock divide ratios
  localparam logic [1:0]  MCLK_DIV_UNDIV = 2'h1;
  localparam logic [1:0]  MCLK_DIV_TIMER = 2'h2;
endpackage
`default_nettype wire

// >>> src/ssc_slave.sv
// Function
// [RULE_01] Shift only on externally supplied serial clock
// [RULE_02] Act as slave only while select low
// [RULE_03] Select high: ignore control, clock, data
// [RULE_04] Select rising mid-word clears counter, shifter
// [RULE_05] Only master clock edges start a word
// [RULE_06] No new word: input bits pass through
// [RULE_07] Software refills transmit before word ends
// [RULE_08] First edge sends current shifter contents
// [RULE_09] Transfers keep running during system sleep
// [RULE_10] Word while full: overwrite, flag overrun
// [RULE_11] End flag: word sent, buffer empty; W1C
// [RULE_12] Full flag on transfer, cleared by read
// [RULE_13] Empty flag on load, cleared by write
// [RULE_14] Overrun when word lands unread; W1C
// [RULE_15] Per-flag enables gate the interrupt request
// [RULE_16] Busy bit shows select low in slave
// [RULE_17] Length field plus one bits, reset seven
// [RULE_18] Mode bit 5 enables input pulls
// [RULE_19] Mode bit 4 undivided master clock
// [RULE_20] Bit 4 clear: timer clock halved
// [RULE_21] Bit order and master/slave selects
// [RULE_22] Mode changes only while channel disabled
// [RULE_23] Software checks empty flag before writing
// [RULE_24] Software waits full flag, then reads
// [RULE_25] Software waits end flag, then disables
// [RULE_26] Sample and drive on polarity/phase edges
`timescale 1ns/1ps
`default_nettype none
module ssc_slave
(
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [ssc_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic [ssc_pkg::DATA_W-1:0]    reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [ssc_pkg::DATA_W-1:0]    reg_rdata_out,
  input  wire logic                          serial_clock_pin_in,
  input  wire logic                          serial_data_in_pin_in,
  input  wire logic                          slave_select_low_pin_n_in,
  output logic                               serial_data_out_pin_out,
  output logic                               serial_data_out_pin_oe_out,
  output logic                               irq_out,
  output logic                               input_pull_enable_out,
  output logic      [1:0]                    master_clock_div_out
);
  import ssc_pkg::*;

  // Pin synchronisers: stage 1 feeds only stage 2
  logic [2:0]  sclk_sync_reg;
  logic [2:0]  sdi_sync_reg;
  logic [2:0]  ssn_sync_reg;
  logic        sclk_f_reg, sdi_f_reg, ssn_f_reg;
  logic        sclk_prev_reg;

  // Mode and control
  logic [3:0]  len_reg;
  logic        pull_reg, undiv_reg, lsbf_reg, clock_phase_select_reg, clock_polarity_select_reg, mst_reg;
  logic        enable_reg, softrst_reg;

  // Datapath and flags
  logic [15:0] txbuf_reg;
  logic [15:0] rxbuf_reg;
  logic [15:0] shift_reg;
  logic [3:0]  cnt_reg;
  logic        tbe_reg, rbf_reg, tend_reg, ovr_reg;
  logic [3:0]  ie_reg;
  logic        sdo_reg;
  logic        sdo_oe_reg;
  logic [15:0] rdata_reg;

  // Decoded strobes and events
  logic        wr_mode, wr_ctrl, wr_txd, wr_intf, wr_inte, rd_rxd;
  logic        active, rise_evt, fall_evt, lead_evt, trail_evt;
  logic        sample_evt, drive_evt, word_done, load_evt, out_bit;
  logic [15:0] len_mask, shift_next, rdata_next;
  logic [3:0]  flags;

  assign wr_mode = reg_wr_in && (reg_addr_in == OFF_MODE);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == OFF_CTRL);
  assign wr_txd  = reg_wr_in && (reg_addr_in == OFF_TXD);
  assign wr_intf = reg_wr_in && (reg_addr_in == OFF_INTF);
  assign wr_inte = reg_wr_in && (reg_addr_in == OFF_INTE);
  assign rd_rxd  = reg_rd_in && (reg_addr_in == OFF_RXD);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sclk_sync_reg <= 3'h0;
      sdi_sync_reg  <= 3'h0;
      ssn_sync_reg  <= 3'h7;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clock_pin_in};
      sdi_sync_reg  <= {sdi_sync_reg[1:0], serial_data_in_pin_in};
      ssn_sync_reg  <= {ssn_sync_reg[1:0], slave_select_low_pin_n_in};
    end
  end

  // A level counts once the last two stages agree
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sclk_f_reg    <= 1'b0;
      sdi_f_reg     <= 1'b0;
      ssn_f_reg     <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      if (sclk_sync_reg[1] == sclk_sync_reg[2])
        sclk_f_reg <= sclk_sync_reg[2];
      if (sdi_sync_reg[1] == sdi_sync_reg[2])
        sdi_f_reg <= sdi_sync_reg[2];
      if (ssn_sync_reg[1] == ssn_sync_reg[2])
        ssn_f_reg <= ssn_sync_reg[2];
      sclk_prev_reg <= sclk_f_reg;
    end
  end

  // Only the master's clock moves the shifter; no internal divider in slave
  assign active     = enable_reg && !mst_reg // RULE_01
                      && !ssn_f_reg && !softrst_reg; // RULE_02 RULE_03
  assign rise_evt   = sclk_f_reg && !sclk_prev_reg;
  assign fall_evt   = !sclk_f_reg && sclk_prev_reg;
  assign lead_evt   = clock_polarity_select_reg ? fall_evt : rise_evt;
  assign trail_evt  = clock_polarity_select_reg ? rise_evt : fall_evt;
  assign sample_evt = active && (clock_phase_select_reg ? trail_evt : lead_evt); // RULE_26
  assign drive_evt  = active && (clock_phase_select_reg ? lead_evt : trail_evt); // RULE_26
  assign word_done  = sample_evt && (cnt_reg == len_reg);
  // A buffered word enters the shifter only between words, never mid-word
  assign load_evt   = !tbe_reg && (cnt_reg == 4'h0) && !sample_evt && !softrst_reg;

  always_comb
  begin
    for (int i = 0; i < 16; i++)
      len_mask[i] = (4'(i) <= len_reg); // RULE_17
  end

  // Received bits leave from the far end, so an unrefreshed shifter echoes input
  always_comb
  begin
    shift_next = 16'h0000;
    if (lsbf_reg) // RULE_21
    begin
      shift_next = shift_reg >> 1;
      shift_next[len_reg] = sdi_f_reg;
    end
    else
    begin
      shift_next = {shift_reg[14:0], sdi_f_reg};
    end
    shift_next = shift_next & len_mask; // RULE_06
  end

  assign out_bit = lsbf_reg ? shift_reg[0] : shift_reg[len_reg];

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      len_reg   <= LEN_RESET;
      pull_reg  <= 1'b0;
      undiv_reg <= 1'b0;
      lsbf_reg  <= 1'b0;
      clock_phase_select_reg  <= 1'b0;
      clock_polarity_select_reg  <= 1'b0;
      mst_reg   <= 1'b0;
    end
    else if (wr_mode && !enable_reg) // RULE_22
    begin
      if (reg_wdata_in[MODE_LEN_MSB:MODE_LEN_LSB] != LEN_PROHIBITED) // RULE_17
        len_reg <= reg_wdata_in[MODE_LEN_MSB:MODE_LEN_LSB];
      pull_reg  <= reg_wdata_in[MODE_PULL]; // RULE_18
      undiv_reg <= reg_wdata_in[MODE_UNDIV]; // RULE_19
      lsbf_reg  <= reg_wdata_in[MODE_LSBFIRST]; // RULE_21
      clock_phase_select_reg  <= reg_wdata_in[MODE_CLOCK_PHASE_SELECT];
      clock_polarity_select_reg  <= reg_wdata_in[MODE_CLOCK_POLARITY_SELECT];
      mst_reg   <= reg_wdata_in[MODE_MASTER]; // RULE_21
    end
  end

  // Soft reset lasts one cycle and reads back 1 meanwhile
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      enable_reg  <= 1'b0;
      softrst_reg <= 1'b0;
    end
    else
    begin
      softrst_reg <= wr_ctrl && reg_wdata_in[CTRL_SOFTRST];
      if (wr_ctrl)
        enable_reg <= reg_wdata_in[CTRL_ENABLE];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      txbuf_reg <= DATA_RESET;
    else if (wr_txd)
      txbuf_reg <= reg_wdata_in; // RULE_05
  end

  // Shifter and bit counter; a deselect between words keeps the word so it can echo
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift_reg <= DATA_RESET;
      cnt_reg   <= 4'h0;
    end
    else if (softrst_reg || (!active && cnt_reg != 4'h0))
    begin
      shift_reg <= DATA_RESET; // RULE_04
      cnt_reg   <= 4'h0; // RULE_03 RULE_04
    end
    else if (sample_evt)
    begin
      shift_reg <= shift_next;
      cnt_reg   <= word_done ? 4'h0 : cnt_reg + 4'h1; // RULE_05
    end
    else if (load_evt)
    begin
      shift_reg <= txbuf_reg; // RULE_13
    end
  end

  // Phase 0 presents the first bit before any edge; phase 1 on the leading edge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end
    else
    begin
      sdo_oe_reg <= active;
      if (drive_evt || (active && !clock_phase_select_reg && cnt_reg == 4'h0 && !sample_evt))
        sdo_reg <= out_bit; // RULE_08 RULE_26
    end
  end

  // Receive buffer; cleared by enabling or soft reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rxbuf_reg <= DATA_RESET;
    else if (word_done)
      rxbuf_reg <= shift_next; // RULE_10
    else if (wr_ctrl && (reg_wdata_in[CTRL_ENABLE] || reg_wdata_in[CTRL_SOFTRST]))
      rxbuf_reg <= DATA_RESET;
  end

  // Flags: a hardware set wins over a same-cycle clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tbe_reg  <= TBE_RESET;
      rbf_reg  <= 1'b0;
      tend_reg <= 1'b0;
      ovr_reg  <= 1'b0;
    end
    else
    begin
      if (load_evt)
        tbe_reg <= 1'b1; // RULE_13
      else if (wr_txd)
        tbe_reg <= 1'b0; // RULE_13
      if (word_done)
        rbf_reg <= 1'b1; // RULE_12
      else if (rd_rxd)
        rbf_reg <= 1'b0; // RULE_12
      if (word_done && tbe_reg)
        tend_reg <= 1'b1; // RULE_11
      else if (wr_intf && reg_wdata_in[INTF_TEND])
        tend_reg <= 1'b0; // RULE_11
      if (word_done && rbf_reg)
        ovr_reg <= 1'b1; // RULE_10 RULE_14
      else if (wr_intf && reg_wdata_in[INTF_OVR])
        ovr_reg <= 1'b0; // RULE_14
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ie_reg <= IE_RESET;
    else if (wr_inte)
      ie_reg <= reg_wdata_in[3:0];
  end

  assign flags = {ovr_reg, tend_reg, rbf_reg, tbe_reg};
  // Pure gating, no clock needed, so sleep cannot stall a wake-up request
  assign irq_out = |(flags & ie_reg); // RULE_15 RULE_09
  assign input_pull_enable_out = pull_reg; // RULE_18
  assign master_clock_div_out  = undiv_reg ? MCLK_DIV_UNDIV : MCLK_DIV_TIMER; // RULE_19 RULE_20
  assign serial_data_out_pin_out    = sdo_reg;
  assign serial_data_out_pin_oe_out = sdo_oe_reg;

  always_comb
  begin
    rdata_next = 16'h0000;
    case (reg_addr_in)
      OFF_MODE:
      begin
        rdata_next[MODE_LEN_MSB:MODE_LEN_LSB] = len_reg;
        rdata_next[MODE_PULL]     = pull_reg;
        rdata_next[MODE_UNDIV]    = undiv_reg;
        rdata_next[MODE_LSBFIRST] = lsbf_reg;
        rdata_next[MODE_CLOCK_PHASE_SELECT]     = clock_phase_select_reg;
        rdata_next[MODE_CLOCK_POLARITY_SELECT]     = clock_polarity_select_reg;
        rdata_next[MODE_MASTER]   = mst_reg;
      end
      OFF_CTRL:
      begin
        rdata_next[CTRL_SOFTRST] = softrst_reg;
        rdata_next[CTRL_ENABLE]  = enable_reg;
      end
      OFF_TXD:
        rdata_next = txbuf_reg;
      OFF_RXD:
        rdata_next = rxbuf_reg & len_mask;
      OFF_INTF:
      begin
        rdata_next[3:0]       = flags;
        rdata_next[INTF_BUSY] = active; // RULE_16
      end
      OFF_INTE:
        rdata_next[3:0] = ie_reg;
      default:
        rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_reg <= DATA_RESET;
    else if (reg_rd_in)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 16'h0000;
  end

  assign reg_rdata_out = rdata_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_word_end;
    sample_evt && (cnt_reg == len_reg);
  endsequence

  sequence s_word_end_full;
    s_word_end and rbf_reg;
  endsequence

  a_tx_write_clears: assert property ((wr_txd && !load_evt) |=> !tbe_reg) // RULE_13
    else $error("write to transmit data left empty flag set");
  a_load_sets_empty: assert property (load_evt // RULE_13
                                      |=> (tbe_reg && shift_reg == $past(txbuf_reg)))
    else $error("buffered word not moved into shifter");
  a_deselect_clears: assert property ((!active && cnt_reg != 4'h0) // RULE_04
                                      |=> (cnt_reg == 4'h0 && shift_reg == 16'h0000))
    else $error("deselect did not clear counter and shifter");
  a_word_sets_full: assert property (s_word_end // RULE_12
                                     |=> (rbf_reg && rxbuf_reg == $past(shift_next)))
    else $error("completed word not captured with full flag");
  a_overrun_sets: assert property (s_word_end_full |=> (ovr_reg && rbf_reg)) // RULE_10
    else $error("overrun not flagged on unread buffer");
  a_end_flag_sets: assert property ((s_word_end and tbe_reg) |=> tend_reg) // RULE_11
    else $error("end flag missing after word with empty buffer");
  a_read_clears_full: assert property ((rd_rxd && !word_done) |=> !rbf_reg) // RULE_12
    else $error("reading receive data did not clear full flag");
  a_no_self_start: assert property ((cnt_reg == 4'h0 && !sample_evt) // RULE_05
                                    |=> (cnt_reg == 4'h0))
    else $error("bit counter advanced without a clock edge");
  a_irq_gating: assert property (((flags & ie_reg) == 4'h0) |-> !irq_out) // RULE_15
    else $error("interrupt raised with no enabled flag");
  a_busy_readback: assert property ((reg_rd_in && reg_addr_in == OFF_INTF) // RULE_16
                                    |=> (reg_rdata_out[INTF_BUSY] == $past(active)))
    else $error("busy bit does not follow select");
  a_ss_blocks: assert property (ssn_f_reg |-> (!sample_evt && !drive_evt)) // RULE_03
    else $error("serial edge acted on while deselected");

endmodule // ssc_slave
`default_nettype wire

// >>> test/ssc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_master_model
(
  input  wire logic        clk_in,
  input  wire logic        miso_in,
  output var  logic        sclk_out,
  output var  logic        ss_n_out,
  output var  logic        mosi_out,
  output var  logic [15:0] word_out,
  output var  logic        done_out
);
  // Half bit period well above the slave's synchroniser delay
  localparam int HALF = 12;
  initial
  begin
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
    word_out = 16'h0000;
    done_out = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge clk_in);
  endtask
  task automatic xfer(input logic [15:0] w, input int nb, input int len1, input logic clock_polarity_select,
                      input logic clock_phase_select, input logic lsb, input logic sel);
    int          b;
    logic [15:0] got;
    got = 16'h0000;
    sclk_out <= clock_polarity_select;
    half();
    ss_n_out <= !sel;
    half();
    for (int i = 0; i < nb; i++)
    begin
      b = lsb ? i : len1 - 1 - i;
      if (!clock_phase_select)
        mosi_out <= w[b];
      half();
      sclk_out <= !clock_polarity_select;
      if (clock_phase_select)
        mosi_out <= w[b];
      else
        got[b] = miso_in;
      half();
      sclk_out <= clock_polarity_select;
      if (clock_phase_select)
        got[b] = miso_in;
    end
    half();
    ss_n_out <= 1'b1;
    // Released line must not keep showing the last bit
    mosi_out <= !mosi_out;
    half();
    if (sel && nb == len1)
    begin
      word_out <= got;
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
    end
  endtask
endmodule // ssc_master_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssc_pkg::*;
  logic        clk, rst, wr, rd, rd_q, sclk, ss_n, mosi, sdo, oe, irq, pull, done;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, mword;
  logic [1:0]  div;
  logic [15:0] rq[$];
  logic [15:0] mq[$];
  int          n_fail = 0;
  int          n_compared = 0;
  // Pulled-up wire when the slave releases its output
  wire         miso = oe ? sdo : 1'b1;

  ssc_slave dut_u
  (
    .clk_in                     (clk),
    .rst_in                     (rst),
    .reg_addr_in                (addr),
    .reg_wdata_in               (wdata),
    .reg_wr_in                  (wr),
    .reg_rd_in                  (rd),
    .reg_rdata_out              (rdata),
    .serial_clock_pin_in        (sclk),
    .serial_data_in_pin_in      (mosi),
    .slave_select_low_pin_n_in  (ss_n),
    .serial_data_out_pin_out    (sdo),
    .serial_data_out_pin_oe_out (oe),
    .irq_out                    (irq),
    .input_pull_enable_out      (pull),
    .master_clock_div_out       (div)
  );
  ssc_master_model master_u
  (
    .clk_in   (clk),
    .miso_in  (miso),
    .sclk_out (sclk),
    .ss_n_out (ss_n),
    .mosi_out (mosi),
    .word_out (mword),
    .done_out (done)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic irq_w(input logic [7:0] a, input logic [15:0] d, input logic e);
    wr_reg(a, d);
    @(posedge clk);
    cmp({15'h0000, irq}, {15'h0000, e});
  endtask
  task automatic set_mode(input logic [15:0] mv);
    // Mode is only writable with the channel disabled
    wr_reg(OFF_CTRL, 16'h0000);
    wr_reg(OFF_MODE, mv);
    wr_reg(OFF_CTRL, 16'h0001);
  endtask
  task automatic word(input logic [15:0] e, input logic [15:0] w, input int n, input logic [2:0] m);
    mq.push_back(e);
    master_u.xfer(w, n, n, m[0], m[1], m[2], 1'b1);
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge clk)
  begin
    rd_q <= rd;
    if (rd_q)
      cmp(rdata, rq.pop_front());
    if (done)
      cmp(mword, mq.pop_front());
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial
  begin
    int          len1;
    logic [2:0]  md;
    logic [15:0] mask, mv, tx, rx, rx2, rx3;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    void'($urandom(39));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFF_MODE, 16'h0700);
    rd_reg(OFF_INTF, 16'h0001);
    rd_reg(OFF_INTE, 16'h0000);
    wr_reg(8'h18, 16'hffff);
    rd_reg(8'h18, 16'h0000);
    cmp({12'h000, irq, pull, div}, 16'h0002);
    $display("Test reset values done");
    wr_reg(OFF_MODE, 16'h0030);
    rd_reg(OFF_MODE, 16'h0730);
    cmp({13'h0000, pull, div}, 16'h0005);
    wr_reg(OFF_MODE, 16'h0f00);
    wr_reg(OFF_CTRL, 16'h0001);
    wr_reg(OFF_MODE, 16'h0130);
    rd_reg(OFF_MODE, 16'h0f00);
    cmp({13'h0000, pull, div}, 16'h0002);
    $display("Test mode register done");
    for (int m = 0; m < 8; m++)
    begin
      md = 3'(m);
      len1 = 2 + $urandom_range(14);
      mask = 16'((32'h0000_0001 << len1) - 32'h0000_0001);
      mv = {4'h0, 4'(len1 - 1), 4'h0, md, 1'b0};
      tx = 16'($urandom);
      rx = 16'($urandom);
      rx2 = 16'($urandom);
      rx3 = 16'($urandom);
      set_mode(mv);
      rd_reg(OFF_MODE, mv);
      wr_reg(OFF_TXD, tx);
      word(tx & mask, rx, len1, md);
      rd_reg(OFF_INTF, 16'h0007);
      rd_reg(OFF_RXD, rx & mask);
      wr_reg(OFF_INTF, 16'h0004);
      rd_reg(OFF_INTF, 16'h0001);
      fork
        word(rx & mask, rx2, len1, md);
        begin
          repeat (40) @(posedge clk);
          rd_reg(OFF_INTF, 16'h0081);
        end
      join
      rd_reg(OFF_INTF, 16'h0007);
      word(rx2 & mask, rx3, len1, md);
      rd_reg(OFF_INTF, 16'h000f);
      rd_reg(OFF_RXD, rx3 & mask);
      wr_reg(OFF_INTF, 16'h000c);
      rd_reg(OFF_INTF, 16'h0001);
    end
    $display("Test transfers in all modes done");
    set_mode(16'h0700);
    master_u.xfer(16'h00ff, 3, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    master_u.xfer(16'h00ff, 8, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    rd_reg(OFF_INTF, 16'h0001);
    word(16'h0000, rx, 8, 3'h0);
    rd_reg(OFF_INTF, 16'h0007);
    rd_reg(OFF_RXD, rx & 16'h00ff);
    $display("Test select abort done");
    irq_w(OFF_INTE, 16'h0008, 1'b0);
    irq_w(OFF_INTE, 16'h0004, 1'b1);
    irq_w(OFF_INTF, 16'h0004, 1'b0);
    irq_w(OFF_INTE, 16'h0002, 1'b0);
    irq_w(OFF_INTE, 16'h0001, 1'b1);
    $display("Test interrupt request done");
    set_mode(16'h0701);
    word(16'h00ff, rx, 8, 3'h0);
    rd_reg(OFF_INTF, 16'h0001);
    set_mode(16'h0700);
    wr_reg(OFF_CTRL, 16'h0003);
    word(16'h0000, rx2, 8, 3'h0);
    rd_reg(OFF_RXD, rx2 & 16'h00ff);
    $display("Test master role and soft reset done");
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
